// *** common/smw_params.svh ***
// Register offsets, field positions, reset values and timing counts
// ==========================================================
// Functional notes
// - Flag register 0x54: bit 7 reserved, bits 6..0 cleared by write.
// - Bits 6-3: half termination, shorted, high-battery, low-ground.
// - Bit 2 flags any open bus, location unknown.
// - Bit 1 ground short, bit 0 battery short, one or both lines.
// - Normal mode passes transmit and receive; inactivity timer stopped.
// - Silent mode ignores transmit, driver off, receive mirrors bus.
// - Standby latches receive low on wake or fault (code latches on wake only); power-on is a wake.
// - Standby inactivity expiry sets software error; stays in standby.
// - Filtered dominant, recessive, dominant phases; traffic ignored.
// - Second filtered dominant declares wake and pulls receive low.
// - Pattern must finish within timeout, else detector restarts.
// - Reset mode holds reset output low, transceiver off, bus to ground.
// - Reset mode watches for wake; wake biases bus, signals receive.
// - Reset mode entered at power-on and when reset pin pulled low.
// - Leaving fail-safe after fault clears goes to reset mode.
// - Over-temp or over-voltage: fail-safe, regulator off, reset low.
// - Fail-safe exits only when temp ok, voltage ok and wake present.
// - Uncleared fault past inactivity time sets software error.
// - Fault kept after four falling edges, each dominant >= 2 us.
`ifndef SMW_PARAMS_SVH
`define SMW_PARAMS_SVH
`define SMW_CLK_MHZ 50
`define SMW_FAULT_ADDR 8'h54
`define SMW_FAULT_RESET 8'h00
`define SMW_FAULT_RSVD_BIT 7
`define SMW_BIT_HALF_TERM 6
`define SMW_BIT_SHORTED 5
`define SMW_BIT_H_BAT 4
`define SMW_BIT_L_GND 3
`define SMW_BIT_OPEN 2
`define SMW_BIT_GND 1
`define SMW_BIT_BAT 0
`define SMW_FAULT_DOM_US 2
`define SMW_FAULT_EDGES 4
`define SMW_WK_FILTER_US 1
`define SMW_WK_TIMEOUT_US 1000
`define SMW_INACTIVE_MS 5
`endif

// *** common/smw_pkg.sv ***
// Types for the mode, wake and fault controller
package smw_pkg;
  typedef enum logic [2:0] {
    SMW_OFF = 3'b000,
    SMW_RESET = 3'b001,
    SMW_FAILSAFE = 3'b010,
    SMW_NORMAL = 3'b011,
    SMW_STANDBY = 3'b100,
    SMW_SILENT = 3'b101
  } smw_mode_t;
  typedef enum logic [1:0] {
    SMW_WK_IDLE = 2'b00,
    SMW_WK_DOM1 = 2'b01,
    SMW_WK_REC = 2'b10
  } smw_wake_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smw_reg_req_t;
  typedef struct packed {
    logic half_term;
    logic shorted;
    logic h_bat;
    logic l_gnd;
    logic open;
    logic gnd;
    logic bat;
  } smw_fault_t;
endpackage

// *** rtl/smw_ctrl.sv ***
// Operating mode, wake pattern and bus-fault flag controller
`timescale 1ns/100ps
`include "smw_params.svh"
module smw_ctrl
  import smw_pkg::*;
#(
  parameter int WK_TIMEOUT_CYC = `SMW_WK_TIMEOUT_US * `SMW_CLK_MHZ,
  parameter int INACTIVE_CYC = `SMW_INACTIVE_MS * 1000 * `SMW_CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Supply and faults (async pins)
  input wire logic power_good_i,
  input wire logic over_temp_i,
  input wire logic temp_recovered_i,
  input wire logic over_volt_i,
  input wire logic volt_recovered_i,
  input wire logic reset_pin_low_i,
  // Mode command from host
  input wire logic cmd_valid_i,
  input wire smw_mode_t cmd_mode_i,
  // Register access
  input wire smw_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // CAN path
  input wire logic txd_i,
  input wire logic bus_dom_i,
  input wire smw_fault_t fault_seen_i,
  output logic tx_dom_o,
  output logic rxd_o,
  output logic bias_active_o,
  // Status
  output smw_mode_t mode_o,
  output logic reset_out_n_o,
  output logic regulator_output_o,
  output logic watchdog_en_o,
  output logic reg_access_en_o,
  output logic software_error_flag_o,
  output logic wake_up_pattern_o
);
  localparam int FILT_CYC = `SMW_WK_FILTER_US * `SMW_CLK_MHZ;
  localparam int DOM_CYC = `SMW_FAULT_DOM_US * `SMW_CLK_MHZ;

  // ==========================================================
  // Input synchronisers: change counts once stages 2 and 3 agree
  localparam int NS = 7;
  logic [NS-1:0] raw, s1, s2, s3, clean, next_clean;
  assign raw = {power_good_i, over_temp_i, temp_recovered_i, over_volt_i,
                volt_recovered_i, reset_pin_low_i, bus_dom_i};
  always_comb begin
    next_clean = clean;
    for (int i = 0; i < NS; i++) begin
      if (s2[i] == s3[i]) begin
        next_clean[i] = s3[i];
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      clean <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      clean <= next_clean;
    end
  end
  logic pg, ot, tr, ov, vr, rpl, dom;
  assign {pg, ot, tr, ov, vr, rpl, dom} = clean;

  // ==========================================================
  // Wake pattern detector
  smw_wake_t wk, next_wk;
  logic [15:0] filt_cnt, next_filt_cnt;
  logic [31:0] to_cnt, next_to_cnt;
  logic dom_d, next_dom_d, wake_hit;
  logic filt_ok;
  assign filt_ok = (filt_cnt > 16'(FILT_CYC));
  always_comb begin
    next_wk = wk;
    next_dom_d = dom;
    next_filt_cnt = (dom != dom_d) ? 16'h0000 :
                    (filt_ok ? filt_cnt : filt_cnt + 16'h0001);
    next_to_cnt = (wk == SMW_WK_IDLE) ? 32'h0 : to_cnt + 32'h1;
    wake_hit = 1'b0;
    case (wk)
      SMW_WK_IDLE: begin
        if (dom && filt_ok) begin
          next_wk = SMW_WK_DOM1;
        end
      end
      SMW_WK_DOM1: begin
        if (!dom && filt_ok) begin
          next_wk = SMW_WK_REC;
        end
      end
      SMW_WK_REC: begin
        if (dom && filt_ok) begin
          next_wk = SMW_WK_IDLE;
          wake_hit = 1'b1;
        end
      end
      default: next_wk = SMW_WK_IDLE;
    endcase
    if (wk != SMW_WK_IDLE && to_cnt >= 32'(WK_TIMEOUT_CYC) && !wake_hit) begin
      next_wk = SMW_WK_IDLE;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wk <= SMW_WK_IDLE;
      filt_cnt <= 16'h0000;
      to_cnt <= 32'h0;
      dom_d <= 1'b0;
    end else begin
      wk <= next_wk;
      filt_cnt <= next_filt_cnt;
      to_cnt <= next_to_cnt;
      dom_d <= next_dom_d;
    end
  end

  // ==========================================================
  // Bus-fault qualification: four qualified dominant bits per fault
  logic [15:0] dom_len, next_dom_len;
  logic [2:0] edge_cnt [7], next_edge_cnt [7];
  logic qual_edge;
  assign qual_edge = dom_d && !dom && dom_len >= 16'(DOM_CYC);
  logic [6:0] fault_vec, fault_set;
  assign fault_vec = fault_seen_i;
  always_comb begin
    next_dom_len = dom ? ((dom_len == 16'hffff) ? dom_len : dom_len + 16'h1)
                       : 16'h0;
    fault_set = '0;
    for (int i = 0; i < 7; i++) begin
      next_edge_cnt[i] = edge_cnt[i];
      if (!fault_vec[i]) begin
        next_edge_cnt[i] = 3'h0;
      end else if (qual_edge) begin
        if (edge_cnt[i] == 3'(`SMW_FAULT_EDGES - 1)) begin
          fault_set[i] = 1'b1;
          next_edge_cnt[i] = 3'h0;
        end else begin
          next_edge_cnt[i] = edge_cnt[i] + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // Fault flag register: set wins over write clear
  logic [6:0] flags, next_flags;
  logic reg_ok;
  always_comb begin
    next_flags = flags;
    if (reg_ok && reg_req_i.wr && reg_req_i.addr == `SMW_FAULT_ADDR) begin
      next_flags = '0;
    end
    next_flags = next_flags | fault_set;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags <= 7'(`SMW_FAULT_RESET);
      dom_len <= 16'h0;
      for (int i = 0; i < 7; i++) begin
        edge_cnt[i] <= 3'h0;
      end
    end else begin
      flags <= next_flags;
      dom_len <= next_dom_len;
      for (int i = 0; i < 7; i++) begin
        edge_cnt[i] <= next_edge_cnt[i];
      end
    end
  end

  // ==========================================================
  // Mode state machine
  smw_mode_t mode, next_mode;
  logic [31:0] inact, next_inact;
  logic software_error_flag, next_swe, rx_latch, next_rx_latch, bias, next_bias;
  logic rpl_d, next_rpl_d;
  logic [7:0] rdata, next_rdata;
  assign reg_ok = (mode == SMW_NORMAL || mode == SMW_STANDBY ||
                   mode == SMW_SILENT);
  always_comb begin
    next_mode = mode;
    next_inact = 32'h0;
    next_swe = software_error_flag;
    next_rx_latch = rx_latch;
    next_bias = bias;
    next_rpl_d = rpl;
    // Clear first so that an expiry in the same cycle still sets the flag
    if (reg_ok && reg_req_i.wr && reg_req_i.addr == `SMW_FAULT_ADDR) begin
      next_swe = 1'b0;
    end
    case (mode)
      SMW_OFF: begin
        if (pg) begin
          next_mode = SMW_RESET;
          next_rx_latch = 1'b1;
        end
      end
      SMW_RESET: begin
        if (wake_hit) begin
          next_bias = 1'b1;
          next_rx_latch = 1'b1;
        end
        // Leave on release of the pin; a level test would exit at once
        if (rpl_d && !rpl) begin
          next_mode = SMW_STANDBY;
        end
      end
      SMW_FAILSAFE: begin
        if (tr && vr && (wake_hit || rx_latch)) begin
          next_mode = SMW_RESET;
        end else begin
          next_inact = (inact == 32'(INACTIVE_CYC)) ? inact : inact + 32'h1;
          if (inact == 32'(INACTIVE_CYC) - 32'h1) begin
            next_swe = 1'b1;
          end
        end
      end
      SMW_STANDBY: begin
        if (wake_hit) begin
          next_rx_latch = 1'b1;
          next_bias = 1'b1;
        end
        if (cmd_valid_i && (cmd_mode_i == SMW_NORMAL ||
                            cmd_mode_i == SMW_SILENT)) begin
          next_mode = cmd_mode_i;
          next_rx_latch = 1'b0;
          next_bias = 1'b1;
        end else begin
          next_inact = (inact == 32'(INACTIVE_CYC)) ? inact : inact + 32'h1;
          if (inact == 32'(INACTIVE_CYC) - 32'h1) begin
            next_swe = 1'b1;
            next_bias = 1'b0;
          end
        end
      end
      SMW_NORMAL, SMW_SILENT: begin
        if (cmd_valid_i && (cmd_mode_i == SMW_NORMAL ||
                            cmd_mode_i == SMW_SILENT ||
                            cmd_mode_i == SMW_STANDBY)) begin
          next_mode = cmd_mode_i;
          next_bias = (cmd_mode_i != SMW_STANDBY);
        end
      end
      default: next_mode = SMW_OFF;
    endcase
    if (mode != SMW_OFF && (ot || ov)) begin
      next_mode = SMW_FAILSAFE;
      next_bias = 1'b0;
      next_inact = (mode == SMW_FAILSAFE) ? next_inact : 32'h0;
    end else if (mode != SMW_OFF && mode != SMW_FAILSAFE && rpl) begin
      next_mode = SMW_RESET;
      next_bias = 1'b0;
    end
    if (!pg) begin
      next_mode = SMW_OFF;
      next_bias = 1'b0;
    end
    next_rdata = 8'h00;
    if (reg_ok && reg_req_i.rd && reg_req_i.addr == `SMW_FAULT_ADDR) begin
      next_rdata = {1'b0, flags};
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode <= SMW_OFF;
      inact <= 32'h0;
      software_error_flag <= 1'b0;
      rx_latch <= 1'b0;
      bias <= 1'b0;
      rpl_d <= 1'b0;
      rdata <= 8'h00;
    end else begin
      mode <= next_mode;
      inact <= next_inact;
      software_error_flag <= next_swe;
      rx_latch <= next_rx_latch;
      bias <= next_bias;
      rpl_d <= next_rpl_d;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    tx_dom_o = 1'b0;
    rxd_o = 1'b1;
    case (mode)
      SMW_NORMAL: begin
        tx_dom_o = !txd_i;
        rxd_o = !dom;
      end
      SMW_SILENT: rxd_o = !dom;
      SMW_STANDBY, SMW_RESET: rxd_o = !rx_latch;
      default: rxd_o = 1'b1;
    endcase
  end
  assign bias_active_o = bias;
  assign mode_o = mode;
  assign reset_out_n_o = !(mode == SMW_RESET || mode == SMW_FAILSAFE ||
                           mode == SMW_OFF);
  assign regulator_output_o = (mode != SMW_OFF && mode != SMW_FAILSAFE);
  assign watchdog_en_o = reg_ok;
  assign reg_access_en_o = reg_ok;
  assign software_error_flag_o = software_error_flag;
  assign wake_up_pattern_o = wake_hit;
  assign reg_rdata_o = rdata;
endmodule

// *** verification/smw_ctrl_assertions.sv ***
// Checker of mode outputs, register read timing and wake pulse shape
`timescale 1ns/100ps
module smw_ctrl_checker
  import smw_pkg::*;
(
  // Clock, reset and inputs
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic over_temp_i,
  input wire logic txd_i,
  input wire smw_reg_req_t reg_req_i,
  // Observed outputs
  input wire logic [7:0] reg_rdata_o,
  input wire logic tx_dom_o,
  input wire smw_mode_t mode_o,
  input wire logic reset_out_n_o,
  input wire logic regulator_output_o,
  input wire logic watchdog_en_o,
  input wire logic reg_access_en_o,
  input wire logic wake_up_pattern_o
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic low_pwr;
  logic live;
  logic reg_off;
  logic is_silent;
  logic is_norm;
  logic no_rd;
  logic pulse;
  assign low_pwr = mode_o inside {SMW_OFF, SMW_RESET, SMW_FAILSAFE};
  assign live = mode_o inside {SMW_NORMAL, SMW_STANDBY, SMW_SILENT};
  assign reg_off = mode_o inside {SMW_OFF, SMW_FAILSAFE};
  assign is_silent = (mode_o == SMW_SILENT);
  assign is_norm = (mode_o == SMW_NORMAL);
  assign no_rd = !reg_req_i.rd;
  assign pulse = wake_up_pattern_o;
  // Synchroniser delay plus one state update stays well inside ten cycles
  property p_heat_entry;
    $rose(over_temp_i) && mode_o != SMW_OFF
      |-> ##[1:10] mode_o == SMW_FAILSAFE;
  endproperty
  reset_out_low_a: assert property (reset_out_n_o == !low_pwr)
    else $error("reset output does not follow mode");
  regulator_off_a: assert property (regulator_output_o == !reg_off)
    else $error("regulator output does not follow mode");
  watchdog_mode_a: assert property (watchdog_en_o == live)
    else $error("watchdog enable does not follow mode");
  reg_access_a: assert property (reg_access_en_o == live)
    else $error("register access enable does not follow mode");
  silent_driver_a: assert property (is_silent |-> !tx_dom_o)
    else $error("driver active in silent mode");
  normal_driver_a: assert property (is_norm |-> tx_dom_o != txd_i)
    else $error("driver does not follow transmit input");
  rdata_idle_a: assert property (no_rd |=> reg_rdata_o == 8'h00)
    else $error("read data without a read");
  rdata_rsvd_a: assert property (reg_rdata_o[7] == 1'b0)
    else $error("reserved bit reads one");
  wake_pulse_a: assert property (pulse |=> !pulse)
    else $error("wake pulse longer than one cycle");
  failsafe_entry_a: assert property (p_heat_entry)
    else $error("no fail-safe entry on over-temperature");
  cover property (mode_o == SMW_NORMAL);
  cover property (wake_up_pattern_o);
  cover property (mode_o == SMW_FAILSAFE);
endmodule

bind smw_ctrl smw_ctrl_checker i_smw_ctrl_checker (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .over_temp_i(over_temp_i),
  .txd_i(txd_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .tx_dom_o(tx_dom_o), .mode_o(mode_o), .reset_out_n_o(reset_out_n_o),
  .regulator_output_o(regulator_output_o), .watchdog_en_o(watchdog_en_o),
  .reg_access_en_o(reg_access_en_o), .wake_up_pattern_o(wake_up_pattern_o)
);

// *** verification/smw_bus_model.sv ***
// Bus-side model that drives the dominant level seen by the controller
`timescale 1ns/100ps
module smw_bus_model (
  // Clock
  input wire logic clk_i,
  // Bus level, high while dominant
  output logic bus_dom_o
);
  // ==========================================================
  // Bus phases, recessive when idle
  initial bus_dom_o = 1'b0;
  task automatic phase(logic dom, int n);
    @(posedge clk_i);
    bus_dom_o <= dom;
    repeat (n - 1) @(posedge clk_i);
  endtask
  // Short phases stay under the filter only when a test asks for it
  task automatic wake_up_pattern(int d1, int r, int d2, int idle);
    phase(1'b1, d1);
    phase(1'b0, r);
    phase(1'b1, d2);
    phase(1'b0, idle);
  endtask
  task automatic toggle(int n, int d);
    repeat (n) begin
      phase(1'b1, d);
      phase(1'b0, 20);
    end
  endtask
endmodule

// *** verification/tb_smw_ctrl.sv ***
// Self-checking bench for the mode, wake and fault controller
`timescale 1ns/100ps
module tb_smw_ctrl;
  import smw_pkg::*;
  // ==========================================================
  // Stimulus and design
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, power_good_i = 1'b0;
  logic over_temp_i = 1'b0, temp_recovered_i = 1'b0, over_volt_i = 1'b0;
  logic volt_recovered_i = 1'b0, reset_pin_low_i = 1'b0;
  logic cmd_valid_i = 1'b0, txd_i = 1'b1, bus_dom_i;
  smw_mode_t cmd_mode_i = SMW_OFF;
  smw_reg_req_t reg_req_i = '0;
  smw_fault_t fault_seen_i = '0;
  logic [7:0] reg_rdata_o;
  logic tx_dom_o, rxd_o, bias_active_o, reset_out_n_o, regulator_output_o;
  logic watchdog_en_o, reg_access_en_o, software_error_flag_o;
  logic wake_up_pattern_o, pend = 1'b0;
  smw_mode_t mode_o;
  int fail_count = 0, checks = 0, wakes = 0, cycles = 0;
  logic [7:0] rd_q[$];
  logic [6:0] f;
  always #10 sys_clk_i = ~sys_clk_i;
  smw_bus_model i_smw_bus_model (.clk_i(sys_clk_i), .bus_dom_o(bus_dom_i));
  // Short counts keep the run brief
  smw_ctrl #(.WK_TIMEOUT_CYC(500), .INACTIVE_CYC(2000)) i_smw_ctrl (
    .sys_clk_i, .rst_b_i, .power_good_i, .over_temp_i, .temp_recovered_i,
    .over_volt_i, .volt_recovered_i, .reset_pin_low_i, .cmd_valid_i,
    .cmd_mode_i, .reg_req_i, .reg_rdata_o, .txd_i, .bus_dom_i, .fault_seen_i,
    .tx_dom_o, .rxd_o, .bias_active_o, .mode_o, .reset_out_n_o,
    .regulator_output_o, .watchdog_en_o, .reg_access_en_o,
    .software_error_flag_o, .wake_up_pattern_o);
  // ==========================================================
  // Tasks
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic reg_op(logic wr, logic [7:0] a, logic [7:0] d,
                        logic [7:0] e);
    @(posedge sys_clk_i);
    reg_req_i <= '{wr, !wr, a, d};
    if (!wr) rd_q.push_back(e);
    @(posedge sys_clk_i);
    reg_req_i <= '0;
  endtask
  task automatic cmd(smw_mode_t m);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_mode_i <= m;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    tick(8);
    cmp("mode", 8'(m), 8'(mode_o));
  endtask
  task automatic pin_pulse();
    reset_pin_low_i <= 1'b1;
    tick(10);
    reset_pin_low_i <= 1'b0;
    tick(10);
    cmp("mode", 8'(SMW_STANDBY), 8'(mode_o));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Read monitor, wake counter and hang limit
  always @(posedge sys_clk_i) begin
    pend <= reg_req_i.rd;
    cycles++;
    if (wake_up_pattern_o === 1'b1) wakes++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  always @(negedge sys_clk_i) begin
    if (pend === 1'b1) cmp("read", rd_q.pop_front(), reg_rdata_o);
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'haecc));
    tick(16);
    rst_b_i <= 1'b1;
    power_good_i <= 1'b1;
    temp_recovered_i <= 1'b1;
    volt_recovered_i <= 1'b1;
    tick(10);
    cmp("mode", 8'(SMW_RESET), 8'(mode_o));
    cmp("reset out", 8'h00, 8'(reset_out_n_o));
    pin_pulse();
    cmp("rxd", 8'h00, 8'(rxd_o));
    reg_op(1'b0, 8'h54, 8'h00, 8'h00);
    reg_op(1'b0, 8'h55, 8'h00, 8'h00);
    $display("test reset and standby done");
    i_smw_bus_model.wake_up_pattern(30, 30, 30, 600);
    i_smw_bus_model.wake_up_pattern(70, 600, 70, 600);
    cmp("wake count", 8'h00, 8'(wakes));
    i_smw_bus_model.wake_up_pattern(70, 70, 70, 600);
    cmp("wake count", 8'h01, 8'(wakes));
    $display("test wake pattern done");
    f = 7'($urandom_range(1, 127));
    fault_seen_i <= f;
    i_smw_bus_model.toggle(5, 90);
    reg_op(1'b0, 8'h54, 8'h00, 8'h00);
    i_smw_bus_model.toggle(5, 110);
    fault_seen_i <= '0;
    reg_op(1'b0, 8'h54, 8'h00, {1'b0, f});
    reg_op(1'b1, 8'h54, 8'h7f, 8'h00);
    reg_op(1'b0, 8'h54, 8'h00, 8'h00);
    $display("test fault flags done");
    for (int i = 0; i < 3; i++) begin
      cmd(i == 0 ? SMW_NORMAL : i == 1 ? SMW_STANDBY : SMW_SILENT);
      repeat (40) @(posedge sys_clk_i) txd_i <= 1'($urandom);
      if (i == 1) continue;
      i_smw_bus_model.phase(1'b1, 20);
      cmp("rxd", 8'h00, 8'(rxd_o));
      i_smw_bus_model.phase(1'b0, 20);
      cmp("rxd", 8'h01, 8'(rxd_o));
    end
    $display("test normal and silent done");
    over_temp_i <= 1'b1;
    temp_recovered_i <= 1'b0;
    tick(10);
    cmp("mode", 8'(SMW_FAILSAFE), 8'(mode_o));
    over_temp_i <= 1'b0;
    temp_recovered_i <= 1'b1;
    tick(10);
    cmp("mode", 8'(SMW_FAILSAFE), 8'(mode_o));
    i_smw_bus_model.wake_up_pattern(70, 70, 70, 20);
    cmp("mode", 8'(SMW_RESET), 8'(mode_o));
    // Leaving fail-safe set nothing in the latch, so a wake here shows
    i_smw_bus_model.wake_up_pattern(70, 70, 70, 20);
    cmp("bias", 8'h01, 8'(bias_active_o));
    cmp("rxd", 8'h00, 8'(rxd_o));
    $display("test fail-safe done");
    pin_pulse();
    tick(2100);
    cmp("swe", 8'h01, 8'(software_error_flag_o));
    cmp("mode", 8'(SMW_STANDBY), 8'(mode_o));
    reg_op(1'b1, 8'h54, 8'h7f, 8'h00);
    tick(2);
    cmp("swe", 8'h00, 8'(software_error_flag_o));
    $display("test inactivity done");
    summarize();
  end
endmodule
